// *** rer_pkg.sv ***
// Purpose: shared constants and types of the remote receiver end-count block
// Assumes: 32-bit apb register bus, one system clock
// Notes:   offsets are byte addresses of aligned words
package rer_pkg;

  // ==========================================================================
  // bus and field widths
  localparam int unsigned RER_ADDR_W   = 12;
  localparam int unsigned RER_DATA_W   = 32;
  localparam int unsigned RER_CNT_W    = 7;
  localparam int unsigned RER_NUM_END  = 3;
  localparam int unsigned RER_NUM_SRC  = 2;
  localparam int unsigned RER_IRQ_W    = 2;

  // ==========================================================================
  // register offsets
  localparam logic [11:0] RER_OFS_END2   = 12'h000;
  localparam logic [11:0] RER_OFS_END3   = 12'h004;
  localparam logic [11:0] RER_OFS_CLKSEL = 12'h008;
  localparam logic [11:0] RER_OFS_STAT   = 12'h00C;
  localparam logic [11:0] RER_OFS_MASK   = 12'h010;
  localparam logic [11:0] RER_OFS_RESULT = 12'h014;

  // ==========================================================================
  // field positions
  localparam int unsigned RER_CNT_MSB      = 6;
  localparam int unsigned RER_CLKSEL_BIT   = 0;
  localparam int unsigned RER_IRQ_DONE     = 0;
  localparam int unsigned RER_IRQ_ABANDON  = 1;
  localparam int unsigned RER_RES_HIT_LSB  = 8;
  localparam int unsigned RER_SYNC_STAGES  = 3;

  // ==========================================================================
  // reset values and special codes
  localparam logic [6:0]  RER_END_RST    = 7'h00;
  localparam logic [1:0]  RER_IRQ_RST    = 2'h0;
  localparam logic [31:0] RER_DATA_ZERO  = 32'h0000_0000;
  localparam logic [6:0]  RER_CNT_NONE   = 7'h00;
  localparam logic [6:0]  RER_CNT_TOP    = 7'h48;

  // ==========================================================================
  // sampling clock source
  typedef enum logic {
    RER_SRC_LF,
    RER_SRC_TIMER
  } rer_src_t;

endpackage : rer_pkg

// *** rer_pin_sync.sv ***
// Purpose: three-stage synchroniser with agreement filter and rise pulse
// Assumes: inputs are asynchronous pins
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ns
module rer_pin_sync import rer_pkg::*; #(
  parameter int unsigned W = 2
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // pins
  input  wire logic [W-1:0] pin_in,
  // filtered result
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  // ==========================================================================
  // per-pin synchroniser
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      logic rise_q;
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= pin_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          lvl_q  <= 1'b0;
          rise_q <= 1'b0;
        end else begin
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
          rise_q <= (s2_q == s3_q) && s3_q && !lvl_q;
        end
      end
      assign level[g] = lvl_q;
      assign rise[g]  = rise_q;
    end
  endgenerate

endmodule : rer_pin_sync

// *** rer_top.sv ***
// Purpose: end bit counts and sampling clock choice of the remote receiver
// Assumes: bit count and max-cycle event come from logic on sys_clk
// Notes:   apb slave with zero wait states, sticky interrupt status
//
// Notes on behaviour
// R1: end-count registers hold seven bits, upper bits always read zero.
// R2: a zero end-count field specifies no particular bit count.
// R3: field value one to seventy-two requires exactly that received bit count.
// R4: software never writes codes seventy-three to one hundred twenty-seven.
// R5: three independent end counts exist; any of them may qualify reception.
// R6: end counts only qualify max-cycle completion, never complete alone.
// R7: clock select bit zero picks low-frequency clock, one picks timer output.
// R8: timer output must be programmed between thirty and thirty-four kilohertz.
// R9: disable receiver before changing clock; write select before others.
// R10: with counts set, max-cycle completes and interrupts only on count match; a mismatch also raises irq via status bit 1 when mask bit 1 is set.
// R11: max-cycle with no matching count returns to leader wait, no completion.
// R12: compare bit count with every nonzero end count; any match qualifies.
// R13: writes to always-zero upper bits change no stored state.
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
module rer_top import rer_pkg::*; #(
  parameter int unsigned ADDR_W = RER_ADDR_W
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // sampling clock pins
  input  wire logic              lf_clock_pin,
  input  wire logic              timer_output_clock,
  // receiver core
  input  wire logic              receiver_enable_bit,
  input  wire logic [6:0]        end_count_first_field,
  input  wire logic [6:0]        rx_bit_count,
  input  wire logic              max_cycle_detect,
  // results
  output logic                   sample_clock_choice,
  output logic                   sample_tick,
  output logic                   rx_complete,
  output logic                   rx_to_leader,
  output logic                   irq
);

  // ==========================================================================
  // apb decode
  logic              setup;
  logic              access;
  logic              wr_lo;
  logic              addr_ok;
  logic [11:0]       ofs;
  logic [31:0]       prdata_q;
  logic              err_q;

  assign ofs    = 12'(paddr);
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;

  always_comb begin
    addr_ok = (ADDR_W <= 12) &&
              ((ofs == RER_OFS_END2) || (ofs == RER_OFS_END3) ||
               (ofs == RER_OFS_CLKSEL) || (ofs == RER_OFS_STAT) ||
               (ofs == RER_OFS_MASK) || (ofs == RER_OFS_RESULT));
  end

  // writes reach only the low byte, where every writable field lives
  assign wr_lo = access && pwrite && pstrb[0] && addr_ok;

  // ==========================================================================
  // configuration registers
  logic [6:0] end2_q;
  logic [6:0] end3_q;
  rer_src_t   clksel_q;
  logic [1:0] mask_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      end2_q <= RER_END_RST;
    end else if (wr_lo && ofs == RER_OFS_END2) begin
      end2_q <= pwdata[RER_CNT_MSB:0]; // R1 R13
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      end3_q <= RER_END_RST;
    end else if (wr_lo && ofs == RER_OFS_END3) begin
      end3_q <= pwdata[RER_CNT_MSB:0]; // R1 R13
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clksel_q <= RER_SRC_LF;
    end else if (wr_lo && ofs == RER_OFS_CLKSEL) begin
      clksel_q <= rer_src_t'(pwdata[RER_CLKSEL_BIT]); // R7 R13
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= RER_IRQ_RST;
    end else if (wr_lo && ofs == RER_OFS_MASK) begin
      mask_q <= pwdata[RER_IRQ_W-1:0];
    end
  end

  // ==========================================================================
  // sampling clock choice
  logic [RER_NUM_SRC-1:0] src_rise;
  logic                   sample_tick_q;

  rer_pin_sync #(
    .W (RER_NUM_SRC)
  ) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pin_in  ({timer_output_clock, lf_clock_pin}),
    .level   (),
    .rise    (src_rise)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sample_tick_q <= 1'b0;
    end else begin
      case (clksel_q)
        RER_SRC_LF:    sample_tick_q <= receiver_enable_bit && src_rise[0]; // R7
        RER_SRC_TIMER: sample_tick_q <= receiver_enable_bit && src_rise[1]; // R7
        default:       sample_tick_q <= 1'b0;
      endcase
    end
  end

  assign sample_tick         = sample_tick_q;
  assign sample_clock_choice = (clksel_q == RER_SRC_TIMER);

  // ==========================================================================
  // end count match
  logic [6:0]             end_cnt [RER_NUM_END];
  logic [RER_NUM_END-1:0] cfg;
  logic [RER_NUM_END-1:0] hit;
  logic                   max_evt;
  logic                   complete_d;
  logic                   abandon_d;

  assign end_cnt[0] = end_count_first_field;
  assign end_cnt[1] = end2_q;
  assign end_cnt[2] = end3_q;

  genvar gi;
  generate
    for (gi = 0; gi < RER_NUM_END; gi++) begin : g_match
      assign cfg[gi] = (end_cnt[gi] != RER_CNT_NONE);               // R2
      assign hit[gi] = cfg[gi] && (end_cnt[gi] == rx_bit_count);    // R3 R12
    end
  endgenerate

  assign max_evt    = max_cycle_detect && receiver_enable_bit;      // R6
  assign complete_d = max_evt && (!(|cfg) || (|hit));               // R5 R10
  assign abandon_d  = max_evt && (|cfg) && !(|hit);                 // R11

  logic       complete_q;
  logic       abandon_q;
  logic [6:0] res_cnt_q;
  logic [2:0] res_hit_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      complete_q <= 1'b0;
      abandon_q  <= 1'b0;
    end else begin
      complete_q <= complete_d; // R10
      abandon_q  <= abandon_d;  // R11
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      res_cnt_q <= RER_CNT_NONE;
      res_hit_q <= 3'h0;
    end else if (max_evt) begin
      res_cnt_q <= rx_bit_count;
      res_hit_q <= hit;
    end
  end

  assign rx_complete  = complete_q;
  assign rx_to_leader = abandon_q;

  // ==========================================================================
  // interrupt status, write one to clear, set wins
  logic [1:0] stat_q;
  logic [1:0] stat_set;
  logic [1:0] stat_clr;

  assign stat_set = {abandon_d, complete_d};
  assign stat_clr = (wr_lo && ofs == RER_OFS_STAT) ? pwdata[RER_IRQ_W-1:0] : RER_IRQ_RST;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stat_q <= RER_IRQ_RST;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set; // R10
    end
  end

  assign irq = |(stat_q & mask_q);

  // ==========================================================================
  // read data, captured in the setup cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_q <= RER_DATA_ZERO;
      err_q    <= 1'b0;
    end else if (setup) begin
      err_q    <= !addr_ok;
      prdata_q <= RER_DATA_ZERO;
      if (!pwrite && addr_ok) begin
        case (ofs)
          RER_OFS_END2:   prdata_q <= {25'h000_0000, end2_q}; // R1
          RER_OFS_END3:   prdata_q <= {25'h000_0000, end3_q}; // R1
          RER_OFS_CLKSEL: prdata_q <= {31'h0000_0000, sample_clock_choice}; // R7
          RER_OFS_STAT:   prdata_q <= {30'h0000_0000, stat_q};
          RER_OFS_MASK:   prdata_q <= {30'h0000_0000, mask_q};
          RER_OFS_RESULT: prdata_q <= {21'h00_0000, res_hit_q, 1'b0, res_cnt_q};
          default:        prdata_q <= RER_DATA_ZERO;
        endcase
      end
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = access && err_q;

  // ==========================================================================
  // checks
  sequence s_read_setup(logic [11:0] o);
    psel && !penable && !pwrite && ofs == o;
  endsequence

  sequence s_write_end2;
    psel && penable && pwrite && pstrb[0] && ofs == RER_OFS_END2;
  endsequence

  property p_end_upper_zero;
    @(posedge sys_clk) disable iff (!rstn)
      s_read_setup(RER_OFS_END2) or s_read_setup(RER_OFS_END3)
      |=> prdata[31:7] == 25'h000_0000;
  endproperty
  a_end_upper_zero: assert property (p_end_upper_zero) // R1
    else $error("end count upper bits not zero");

  property p_none_cfg_completes;
    @(posedge sys_clk) disable iff (!rstn)
      max_evt && end2_q == RER_CNT_NONE && end3_q == RER_CNT_NONE &&
      end_count_first_field == RER_CNT_NONE |=> rx_complete && !rx_to_leader;
  endproperty
  a_none_cfg_completes: assert property (p_none_cfg_completes) // R2
    else $error("unconfigured counts did not complete");

  property p_end2_match;
    @(posedge sys_clk) disable iff (!rstn)
      max_evt && end2_q != RER_CNT_NONE && end2_q == rx_bit_count
      |=> rx_complete && stat_q[RER_IRQ_DONE];
  endproperty
  a_end2_match: assert property (p_end2_match) // R3
    else $error("matching second count did not complete");

  property p_first_match;
    @(posedge sys_clk) disable iff (!rstn)
      max_evt && end_count_first_field != RER_CNT_NONE &&
      end_count_first_field == rx_bit_count |=> rx_complete;
  endproperty
  a_first_match: assert property (p_first_match) // R5
    else $error("matching first count did not complete");

  property p_only_on_max;
    @(posedge sys_clk) disable iff (!rstn)
      rx_complete || rx_to_leader |-> $past(max_cycle_detect && receiver_enable_bit);
  endproperty
  a_only_on_max: assert property (p_only_on_max) // R6
    else $error("completion without max cycle event");

  property p_tick_source;
    @(posedge sys_clk) disable iff (!rstn)
      sample_tick |-> $past(src_rise[1] && clksel_q == RER_SRC_TIMER ||
                            src_rise[0] && clksel_q == RER_SRC_LF);
  endproperty
  a_tick_source: assert property (p_tick_source) // R7
    else $error("sample tick from unselected source");

  property p_clksel_read;
    @(posedge sys_clk) disable iff (!rstn)
      s_read_setup(RER_OFS_CLKSEL)
      |=> prdata == {31'h0000_0000, $past(sample_clock_choice)};
  endproperty
  a_clksel_read: assert property (p_clksel_read) // R7
    else $error("clock select read wrong");

  property p_irq_follows;
    @(posedge sys_clk) disable iff (!rstn)
      rx_complete && mask_q[RER_IRQ_DONE] |-> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) // R10
    else $error("completion without interrupt");

  property p_mismatch;
    @(posedge sys_clk) disable iff (!rstn)
      max_evt && (|cfg) && !(|hit) |=> rx_to_leader && !rx_complete;
  endproperty
  a_mismatch: assert property (p_mismatch) // R11
    else $error("mismatch did not return to leader");

  property p_any_hit;
    @(posedge sys_clk) disable iff (!rstn)
      rx_complete && $past(|cfg) |-> $past(|hit) ##0 res_hit_q != 3'h0;
  endproperty
  a_any_hit: assert property (p_any_hit) // R12
    else $error("completion without any count match");

  property p_upper_ignored;
    @(posedge sys_clk) disable iff (!rstn)
      s_write_end2 |=> end2_q == $past(pwdata[RER_CNT_MSB:0]);
  endproperty
  a_upper_ignored: assert property (p_upper_ignored) // R13
    else $error("end count write stored wrong value");

endmodule : rer_top

// *** rer_pin_model.sv ***
// Purpose: far-side model driving the two sampling clock pins
// Assumes: half periods are given in sys_clk cycles, each at least 3
// Notes:   both clocks run free and are scaled down to keep the run short
`timescale 1ns/1ns
module rer_pin_model #(
  parameter int LF_HALF = 16,
  parameter int TM_HALF = 17
) (
  // clock
  input  wire logic sys_clk,
  // pins
  output logic      lf_clock_pin,
  output logic      timer_output_clock
);
  int lf_n = 0;
  int tm_n = 0;
  initial lf_clock_pin = 1'b0;
  initial timer_output_clock = 1'b0;

  // ==========================================================================
  // square waves; timer kept within its band just below the low clock
  always @(posedge sys_clk) begin
    lf_n <= (lf_n == LF_HALF - 1) ? 0 : lf_n + 1;
    tm_n <= (tm_n == TM_HALF - 1) ? 0 : tm_n + 1;
    if (lf_n == LF_HALF - 1) lf_clock_pin <= ~lf_clock_pin;
    if (tm_n == TM_HALF - 1) timer_output_clock <= ~timer_output_clock;
  end
endmodule : rer_pin_model

// *** rer_top_bench.sv ***
// Purpose: self-checking bench of the end-count and clock select block
// Assumes: zero-wait apb slave, pulses one cycle after a taken event
// Notes:   random counts from a fixed seed mixed with corner cases
`timescale 1ns/1ns
module rer_top_bench import rer_pkg::*;;
  logic        sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [3:0]  pstrb = 0;
  logic        pready, pslverr, err, lf_clock_pin, timer_output_clock;
  logic        receiver_enable_bit = 0, max_cycle_detect = 0;
  logic [6:0]  end_count_first_field = 0, rx_bit_count = 0, f2, f3, n;
  logic        sample_clock_choice, sample_tick, rx_complete, rx_to_leader, irq;
  logic        counting = 0, sel_q = 0, pin_d = 0, ev_d = 0, cm;
  logic [2:0]  h;
  logic [31:0] r;
  int          n_mismatch = 0, num_checks = 0, seed = 66420, cyc = 0;
  int          n_tick = 0, n_rise = 0;

  rer_top u_rer_top (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lf_clock_pin(lf_clock_pin),
    .timer_output_clock(timer_output_clock), .receiver_enable_bit(receiver_enable_bit),
    .end_count_first_field(end_count_first_field), .rx_bit_count(rx_bit_count),
    .max_cycle_detect(max_cycle_detect), .sample_clock_choice(sample_clock_choice),
    .sample_tick(sample_tick), .rx_complete(rx_complete), .rx_to_leader(rx_to_leader),
    .irq(irq));
  rer_pin_model u_rer_pin_model (.sys_clk(sys_clk), .lf_clock_pin(lf_clock_pin),
    .timer_output_clock(timer_output_clock));

  always #2 sys_clk = ~sys_clk;

  // ==========================================================================
  // helpers
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    logic rdy;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge sys_clk);
    penable <= 1;
    // answer taken at the edge where pready is seen high; the bench timeout ends a hang
    do begin
      @(posedge sys_clk);
      rdat = prdata; err = pslverr; rdy = pready;
    end while (rdy !== 1'b1);
    psel <= 0; penable <= 0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0000_0000, 4'h0);
    chk(nm, rdat, exp);
  endtask : rd

  // event at one edge, pulse in the next cycle only
  task automatic ev(input logic [6:0] c, input logic en, input logic [1:0] exp);
    max_cycle_detect <= 1; rx_bit_count <= c; receiver_enable_bit <= en;
    @(posedge sys_clk);
    max_cycle_detect <= 0;
    @(negedge sys_clk);
    chk("pulses", {rx_to_leader, rx_complete}, exp);
    @(negedge sys_clk);
    chk("pulses_off", {rx_to_leader, rx_complete}, 2'b00);
    @(posedge sys_clk);
  endtask : ev

  function automatic logic [6:0] pick(input logic [31:0] v);
    return v[0] ? 7'h00 : 7'(1 + (v[15:8] % 72));
  endfunction : pick

  task automatic ticks(input logic s, input logic en);
    receiver_enable_bit <= 0;
    wr(RER_OFS_CLKSEL, {31'h0, s});
    sel_q <= s; receiver_enable_bit <= en;
    repeat (20) @(posedge sys_clk);
    counting <= 1;
    repeat (2000) @(posedge sys_clk);
    counting <= 0;
    @(posedge sys_clk);
    chk("clk_choice", sample_clock_choice, s);
    if (en) chk("tick_vs_rise", (n_tick - n_rise) inside {-1, 0, 1}, 1'b1);
    else chk("tick_off", n_tick, 0);
  endtask : ticks

  // ==========================================================================
  // monitors and timeout
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    pin_d <= sel_q ? timer_output_clock : lf_clock_pin;
    ev_d <= max_cycle_detect & receiver_enable_bit;
    if (rstn && (rx_complete | rx_to_leader) && !ev_d) chk("spurious", 1, 0);
    if (!counting) begin
      n_tick <= 0;
      n_rise <= 0;
    end else begin
      n_tick <= n_tick + sample_tick;
      n_rise <= n_rise + ((sel_q ? timer_output_clock : lf_clock_pin) & ~pin_d);
    end
    if (cyc == 30000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1;
    @(posedge sys_clk);
    for (int a = 0; a < 24; a += 4) rd("reset_val", 12'(a), 32'h0000_0000);
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      f2 = pick(r); f3 = pick(~r);
      wr(RER_OFS_CLKSEL, r);
      wr(RER_OFS_END2, {r[31:7], f2}); wr(RER_OFS_END3, {~r[31:7], f3});
      rd("end2", RER_OFS_END2, {25'h0, f2});
      rd("end3", RER_OFS_END3, {25'h0, f3});
      rd("clksel", RER_OFS_CLKSEL, {31'h0, r[0]});
      chk("clk_out", sample_clock_choice, r[0]);
    end
    for (int c = 0; c <= RER_CNT_TOP; c++) begin
      wr(RER_OFS_END3, c);
      rd("code", RER_OFS_END3, c);
    end
    wr(RER_OFS_END2, 32'h0000_0011);
    apb(1, RER_OFS_END2, 32'h0000_0022, 4'hE);
    rd("strb_off", RER_OFS_END2, 32'h0000_0011);
    apb(0, 12'h018, 32'h0, 4'h0);
    chk("unmap_err", {err, rdat}, {1'b1, 32'h0000_0000});
    $display("test registers done");

    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      end_count_first_field <= pick($random(seed));
      f2 = pick($random(seed)); f3 = pick(r);
      wr(RER_OFS_END2, f2); wr(RER_OFS_END3, f3);
      n = r[1] ? f2 : (r[2] ? end_count_first_field : 7'(r[23:16] % 73));
      h = {f3 != 0 && f3 == n, f2 != 0 && f2 == n,
           end_count_first_field != 0 && end_count_first_field == n};
      cm = (h != 0) || (f2 == 0 && f3 == 0 && end_count_first_field == 0);
      ev(n, 1, {~cm, cm});
      rd("result", RER_OFS_RESULT, {21'h0, h, 1'b0, n});
      rd("stat", RER_OFS_STAT, {30'h0, ~cm, cm});
      wr(RER_OFS_STAT, 32'h0000_0003);
    end
    ev(n, 0, 2'b00);
    rd("stat_off", RER_OFS_STAT, 32'h0000_0000);
    $display("test match done");

    end_count_first_field <= 0;
    wr(RER_OFS_END2, 0); wr(RER_OFS_END3, 0); wr(RER_OFS_MASK, 1);
    ev(7'h05, 1, 2'b01);
    chk("irq_on", irq, 1'b1);
    wr(RER_OFS_STAT, 1);
    chk("irq_clr", irq, 1'b0);
    wr(RER_OFS_END2, 7'h48);
    ev(7'h47, 1, 2'b10);
    chk("irq_mask", irq, 1'b0);
    wr(RER_OFS_MASK, 3);
    chk("irq_abandon", irq, 1'b1);
    wr(RER_OFS_STAT, 2);
    chk("irq_off", irq, 1'b0);
    $display("test interrupt done");

    ticks(0, 1);
    ticks(1, 1);
    ticks(1, 0);
    $display("test sampling done");
    end_sim();
  end
endmodule : rer_top_bench
